// File: design/scsw_beat.sv
// Heartbeat divider producing a toggling liveness level.
`timescale 1ns/1ps
module scsw_beat #(
  parameter int unsigned PERIOD = scsw_pkg::HEARTBEAT_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Control.
  input wire logic run_i,
  // Heartbeat level.
  output logic beat_q
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wrap;
  assign wrap = (cnt_q == 32'(PERIOD - 1));
  assign cnt_d = (!run_i || wrap) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 32'h0000_0000;
      beat_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (run_i && wrap) begin
        beat_q <= ~beat_q;
      end
    end
  end
endmodule

// File: design/scsw_pkg.sv
// Package of constants for the servo command-mode status word block.
package scsw_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned HEARTBEAT_MS = 500;
  localparam int unsigned HEARTBEAT_CYC = CLK_HZ / 1000 * HEARTBEAT_MS;
  localparam int unsigned ENC_COUNTS_PER_REV = 16384;
  localparam logic [3:0] WORD_MOTION = 4'h0;
  localparam logic [3:0] WORD_DRIVE = 4'h1;
  localparam logic [3:0] WORD_SPEED = 4'h9;
  localparam int W0_MODE = 15;
  localparam int W0_OK = 14;
  localparam int W0_CFG_ERR = 13;
  localparam int W0_CMD_ERR = 12;
  localparam int W0_IN_ERR = 11;
  localparam int W0_POS_INV = 10;
  localparam int W0_MOVE_DONE = 7;
  localparam int W0_DECEL = 6;
  localparam int W0_ACCEL = 5;
  localparam int W0_HOME = 4;
  localparam int W0_STOPPED = 3;
  localparam int W0_HOLD = 2;
  localparam int W0_CCW = 1;
  localparam int W0_CW = 0;
  localparam int W1_STAGE_ON = 15;
  localparam int W1_STALL = 14;
  localparam int W1_ACK = 13;
  localparam int W1_ENC_ERR = 12;
  localparam int W1_BEAT = 11;
  localparam int W1_TORQUE = 10;
  localparam int W1_JOG_INV = 9;
  localparam int W1_DISCREP = 8;
  localparam int W1_DRV_FAULT = 7;
  localparam int W1_LINK_LOST = 6;
  localparam int W1_SAFE_OFF = 5;
  localparam int W1_HOT = 4;
  localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// File: design/scsw_status.sv
// Command-mode status words and velocity report builder.
`timescale 1ns/1ps
module scsw_status #(
  parameter int unsigned HEARTBEAT_CYC = scsw_pkg::HEARTBEAT_CYC,
  parameter bit SAFETY_OPTION = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Operating state, same clock domain.
  input wire logic config_mode,
  input wire logic internal_fault,
  input wire logic config_missing,
  input wire logic power_stage_on,
  // Command events, one-cycle pulses.
  input wire logic ev_invalid_cmd,
  input wire logic ev_move_cmd,
  input wire logic ev_follower_cmd,
  input wire logic ev_jog_cmd,
  input wire logic ev_enable_cmd,
  input wire logic ev_enable_preset,
  input wire logic ev_disable_cmd,
  input wire logic ev_config_switch,
  input wire logic ev_preset_done,
  input wire logic ev_reset_done,
  // Motion events and levels from the profile logic.
  input wire logic ev_move_end_ok,
  input wire logic ev_follower_end,
  input wire logic ev_home_done,
  input wire logic ev_limit_hit,
  input wire logic ev_jog_into_limit,
  input wire logic ev_home_far_limit,
  input wire logic ev_stall_stopped_big,
  input wire logic ev_jog_invalid,
  input wire logic ev_jog_valid,
  input wire logic ev_link_restored,
  input wire logic moving,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic in_hold,
  input wire logic torque_limited,
  input wire logic pos_diff_big,
  input wire logic pos_err_over,
  input wire logic signed [15:0] velocity,
  // Host handshake bits, same clock domain.
  input wire logic host_preset_bit,
  input wire logic host_reset_bit,
  // Fault and condition sources.
  input wire logic enc_power_up_err,
  input wire logic enc_status_err,
  input wire logic over_temp,
  input wire logic over_current,
  input wire logic proc_hot,
  input wire logic discrepancy_timeout,
  // Pins from outside the clock domain.
  input wire logic estop_pin,
  input wire logic safety_input_a_n,
  input wire logic safety_input_b_n,
  input wire logic [3:0] inputs_active_pin,
  // Exchange strobe from the network side.
  input wire logic exchange,
  // Reported words.
  output logic [15:0] motion_status_word,
  output logic [15:0] drive_status_word,
  output logic [15:0] motor_speed_report
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic estop_prev_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 7'h03;
      pin_s2_q <= 7'h03;
    end else begin
      pin_s1_q <= {estop_pin, inputs_active_pin, safety_input_b_n, safety_input_a_n};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic safe_a_off;
  logic safe_b_off;
  logic estop_s;
  logic [3:0] in_s;
  assign safe_a_off = pin_s2_q[0];
  assign safe_b_off = pin_s2_q[1];
  assign in_s = pin_s2_q[5:2];
  assign estop_s = pin_s2_q[6];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      estop_prev_q <= 1'b0;
    end else begin
      estop_prev_q <= estop_s;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Event decode.
  logic safe_off_engaged;
  logic estop_rise;
  logic err_reset;
  logic set_cmd_err;
  logic set_in_err;
  logic set_pos_inv;
  logic enable_no_preset;
  assign safe_off_engaged = SAFETY_OPTION && (safe_a_off || safe_b_off);
  assign estop_rise = estop_s && !estop_prev_q;
  assign err_reset = ev_reset_done;
  assign enable_no_preset = ev_enable_cmd && !ev_enable_preset;
  assign set_cmd_err = ev_invalid_cmd
    || ((ev_move_cmd || ev_follower_cmd || ev_jog_cmd) && !power_stage_on)
    || (ev_disable_cmd && moving)
    || (ev_config_switch && power_stage_on)
    || (enable_no_preset && pos_diff_big)
    || (ev_enable_cmd && safe_off_engaged);
  assign set_in_err = estop_rise || ev_limit_hit || ev_jog_into_limit || ev_home_far_limit;
  assign set_pos_inv = enc_power_up_err || (enable_no_preset && pos_diff_big) || ev_stall_stopped_big;
  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags.
  logic cmd_err_q;
  logic in_err_q;
  logic pos_inv_q;
  logic move_done_q;
  logic stall_q;
  logic jog_inv_q;
  logic link_lost_q;
  logic discrep_q;
  logic home_q;
  logic follower_q;
  scsw_sticky u_cmd_err (
    .clk(clk), .nrst(nrst), .set_i(set_cmd_err), .clr_i(err_reset), .flag_q(cmd_err_q)
  );
  scsw_sticky u_in_err (
    .clk(clk), .nrst(nrst), .set_i(set_in_err), .clr_i(err_reset), .flag_q(in_err_q)
  );
  scsw_sticky u_pos_inv (
    .clk(clk), .nrst(nrst), .set_i(set_pos_inv), .clr_i(1'b0), .flag_q(pos_inv_q)
  );
  scsw_sticky u_move_done (
    .clk(clk), .nrst(nrst), .set_i(ev_move_end_ok),
    .clr_i(ev_move_cmd || ev_preset_done || err_reset), .flag_q(move_done_q)
  );
  scsw_sticky u_stall (
    .clk(clk), .nrst(nrst), .set_i(pos_err_over), .clr_i(err_reset), .flag_q(stall_q)
  );
  scsw_sticky u_jog_inv (
    .clk(clk), .nrst(nrst), .set_i(ev_jog_invalid),
    .clr_i(ev_jog_valid || err_reset), .flag_q(jog_inv_q)
  );
  scsw_sticky u_link (
    .clk(clk), .nrst(nrst), .set_i(ev_link_restored), .clr_i(err_reset), .flag_q(link_lost_q)
  );
  scsw_sticky u_discrep (
    .clk(clk), .nrst(nrst), .set_i(SAFETY_OPTION && discrepancy_timeout), .clr_i(1'b0),
    .flag_q(discrep_q)
  );
  scsw_sticky u_home (
    .clk(clk), .nrst(nrst), .set_i(ev_home_done),
    .clr_i(ev_move_cmd || ev_follower_cmd || ev_jog_cmd), .flag_q(home_q)
  );
  scsw_sticky u_follow (
    .clk(clk), .nrst(nrst), .set_i(ev_follower_cmd), .clr_i(ev_follower_end), .flag_q(follower_q)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge handshake and heartbeat.
  logic ack_q;
  logic ack_d;
  logic ack_pending;
  logic host_bit_hi;
  logic beat;
  assign host_bit_hi = host_preset_bit || host_reset_bit;
  assign ack_pending = ev_preset_done || ev_reset_done;
  assign ack_d = ack_pending ? 1'b1 : (host_bit_hi ? ack_q : 1'b0);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end
  scsw_beat #(
    .PERIOD(HEARTBEAT_CYC)
  ) u_beat (
    .clk(clk), .nrst(nrst), .run_i(!config_mode), .beat_q(beat)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Word assembly.
  logic [15:0] w0_live;
  logic [15:0] w1_live;
  logic [3:0] in_view;
  logic stopped;
  assign stopped = !moving && !follower_q;
  assign in_view = SAFETY_OPTION ? {!safe_b_off, !safe_a_off, in_s[1:0]} : in_s;
  always_comb begin
    w0_live = scsw_pkg::WORD_RESET;
    w0_live[scsw_pkg::W0_MODE] = config_mode;
    w0_live[scsw_pkg::W0_OK] = !internal_fault;
    w0_live[scsw_pkg::W0_CFG_ERR] = config_missing;
    w0_live[scsw_pkg::W0_CMD_ERR] = cmd_err_q;
    w0_live[scsw_pkg::W0_IN_ERR] = in_err_q;
    w0_live[scsw_pkg::W0_POS_INV] = pos_inv_q;
    w0_live[scsw_pkg::W0_MOVE_DONE] = move_done_q;
    w0_live[scsw_pkg::W0_DECEL] = moving && decelerating;
    w0_live[scsw_pkg::W0_ACCEL] = moving && accelerating;
    w0_live[scsw_pkg::W0_HOME] = home_q;
    w0_live[scsw_pkg::W0_STOPPED] = stopped;
    w0_live[scsw_pkg::W0_HOLD] = in_hold;
    w0_live[scsw_pkg::W0_CCW] = moving && velocity < 0;
    w0_live[scsw_pkg::W0_CW] = moving && velocity > 0;
  end
  always_comb begin
    w1_live = scsw_pkg::WORD_RESET;
    w1_live[scsw_pkg::W1_STAGE_ON] = power_stage_on;
    w1_live[scsw_pkg::W1_STALL] = stall_q;
    w1_live[scsw_pkg::W1_ACK] = ack_q;
    w1_live[scsw_pkg::W1_ENC_ERR] = enc_status_err;
    w1_live[scsw_pkg::W1_BEAT] = beat && !config_mode;
    w1_live[scsw_pkg::W1_TORQUE] = moving && torque_limited;
    w1_live[scsw_pkg::W1_JOG_INV] = jog_inv_q;
    w1_live[scsw_pkg::W1_DISCREP] = discrep_q;
    w1_live[scsw_pkg::W1_DRV_FAULT] = over_temp || over_current || safe_off_engaged;
    w1_live[scsw_pkg::W1_LINK_LOST] = link_lost_q;
    w1_live[scsw_pkg::W1_SAFE_OFF] = safe_off_engaged;
    w1_live[scsw_pkg::W1_HOT] = proc_hot;
    w1_live[3:0] = in_view;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Snapshot registers, loaded together on each exchange.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motion_status_word <= scsw_pkg::WORD_RESET;
      drive_status_word <= scsw_pkg::WORD_RESET;
      motor_speed_report <= scsw_pkg::WORD_RESET;
    end else if (exchange) begin
      motion_status_word <= w0_live;
      drive_status_word <= w1_live;
      motor_speed_report <= velocity;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_snap_same;
    @(posedge clk) disable iff (!nrst)
      exchange |=> (motion_status_word == $past(w0_live)) && (drive_status_word == $past(w1_live));
  endproperty
  a_snap_same: assert property (p_snap_same) else $error("status words not captured together");
  property p_speed;
    @(posedge clk) disable iff (!nrst)
      exchange |=> motor_speed_report == $past(velocity);
  endproperty
  a_speed: assert property (p_speed) else $error("velocity not captured");
  property p_cmd_err_hold;
    @(posedge clk) disable iff (!nrst)
      cmd_err_q && !err_reset |=> cmd_err_q;
  endproperty
  a_cmd_err_hold: assert property (p_cmd_err_hold) else $error("command error lost without reset");
  property p_in_err_set;
    @(posedge clk) disable iff (!nrst)
      ev_limit_hit |=> in_err_q;
  endproperty
  a_in_err_set: assert property (p_in_err_set) else $error("input error not set");
  property p_move_done_clr;
    @(posedge clk) disable iff (!nrst)
      ev_move_cmd && !ev_move_end_ok |=> !move_done_q;
  endproperty
  a_move_done_clr: assert property (p_move_done_clr) else $error("move done not cleared");
  property p_ack_hold;
    @(posedge clk) disable iff (!nrst)
      ack_q && host_bit_hi |=> ack_q;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack fell while host bit high");
  property p_discrep_stick;
    @(posedge clk) disable iff (!nrst)
      discrep_q |=> discrep_q [*4];
  endproperty
  a_discrep_stick: assert property (p_discrep_stick) else $error("discrepancy flag cleared");
  property p_pos_inv_stick;
    @(posedge clk) disable iff (!nrst)
      pos_inv_q && err_reset |=> pos_inv_q;
  endproperty
  a_pos_inv_stick: assert property (p_pos_inv_stick) else $error("position invalid cleared");
  property p_follow_stop;
    @(posedge clk) disable iff (!nrst)
      ev_follower_cmd |=> !stopped;
  endproperty
  a_follow_stop: assert property (p_follow_stop) else $error("stopped high in follower move");
  property p_in_err_hold;
    @(posedge clk) disable iff (!nrst)
      in_err_q && !err_reset |=> in_err_q;
  endproperty
  a_in_err_hold: assert property (p_in_err_hold) else $error("input error lost without reset");
  property p_cmd_err_clr;
    @(posedge clk) disable iff (!nrst)
      err_reset && !set_cmd_err |=> !cmd_err_q;
  endproperty
  a_cmd_err_clr: assert property (p_cmd_err_clr) else $error("command error survived reset");
  property p_enable_safe_off;
    @(posedge clk) disable iff (!nrst)
      ev_enable_cmd && safe_off_engaged |=> cmd_err_q;
  endproperty
  a_enable_safe_off: assert property (p_enable_safe_off) else $error("enable in safe off not refused");
  property p_pos_inv_set;
    @(posedge clk) disable iff (!nrst)
      set_pos_inv |=> pos_inv_q;
  endproperty
  a_pos_inv_set: assert property (p_pos_inv_set) else $error("position invalid not set");
  property p_stall_set;
    @(posedge clk) disable iff (!nrst)
      pos_err_over |=> stall_q;
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall flag not set");
  property p_stall_clr;
    @(posedge clk) disable iff (!nrst)
      err_reset && !pos_err_over |=> !stall_q;
  endproperty
  a_stall_clr: assert property (p_stall_clr) else $error("stall flag survived reset");
  property p_jog_ok;
    @(posedge clk) disable iff (!nrst)
      ev_jog_valid && !ev_jog_invalid |=> !jog_inv_q;
  endproperty
  a_jog_ok: assert property (p_jog_ok) else $error("invalid jog flag not cleared");
  property p_ack_rise;
    @(posedge clk) disable iff (!nrst)
      ack_pending |=> ack_q;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack not raised on completion");
  property p_ack_fall;
    @(posedge clk) disable iff (!nrst)
      !host_bit_hi && !ack_pending |=> !ack_q;
  endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("ack held after host bit low");
  property p_beat_still;
    @(posedge clk) disable iff (!nrst)
      config_mode |=> $stable(beat);
  endproperty
  a_beat_still: assert property (p_beat_still) else $error("heartbeat toggled in configuration");
  property p_home_clr;
    @(posedge clk) disable iff (!nrst)
      (ev_move_cmd || ev_jog_cmd || ev_follower_cmd) && !ev_home_done |=> !home_q;
  endproperty
  a_home_clr: assert property (p_home_clr) else $error("homing done kept after new motion");
  property p_stop_word;
    @(posedge clk) disable iff (!nrst)
      exchange && moving |=> !motion_status_word[scsw_pkg::W0_STOPPED];
  endproperty
  a_stop_word: assert property (p_stop_word) else $error("stopped reported while moving");
  c_reset_ack: cover property (@(posedge clk) disable iff (!nrst) ev_reset_done ##1 ack_q ##[1:20] !ack_q);
  c_move_done: cover property (@(posedge clk) disable iff (!nrst) ev_move_end_ok ##1 move_done_q);
  c_beat: cover property (@(posedge clk) disable iff (!nrst) $changed(beat));
  c_follow: cover property (@(posedge clk) disable iff (!nrst) ev_follower_cmd ##1 follower_q ##[1:50] !follower_q);
  c_estop: cover property (@(posedge clk) disable iff (!nrst) estop_rise ##1 in_err_q);
endmodule

// File: design/scsw_sticky.sv
// Sticky flag cell with set-over-clear priority.
`timescale 1ns/1ps
module scsw_sticky (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Control.
  input wire logic set_i,
  input wire logic clr_i,
  // Flag.
  output logic flag_q
);
  logic flag_d;
  assign flag_d = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_q);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// File: verification/scsw_host_model.sv
// Host controller model that strobes cyclic exchanges and drives command bits.
`timescale 1ns/1ps
module scsw_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Cyclic exchange and command bits.
  output logic exchange,
  output logic host_preset_bit,
  output logic host_reset_bit,
  // Reported words.
  input wire logic [15:0] motion_status_word,
  input wire logic [15:0] drive_status_word,
  input wire logic [15:0] motor_speed_report,
  // Captured copies.
  output logic [15:0] cap0,
  output logic [15:0] cap1,
  output logic [15:0] cap_sp
);
  initial begin
    exchange = 1'b0;
    host_preset_bit = 1'b0;
    host_reset_bit = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One exchange; all three words are taken at the same instant.
  task automatic xchg();
    @(negedge clk);
    exchange = 1'b1;
    @(negedge clk);
    exchange = 1'b0;
    @(negedge clk);
    cap0 = motion_status_word;
    cap1 = drive_status_word;
    cap_sp = motor_speed_report;
  endtask
  // Command bits stay put until the host lowers them to finish a handshake.
  task automatic bits(input logic p, input logic r);
    @(negedge clk);
    host_preset_bit = p;
    host_reset_bit = r;
  endtask
endmodule

// File: verification/scsw_status_tb_top.sv
// Self-checking bench for the command-mode status word block.
`timescale 1ns/1ps
module scsw_status_tb_top;
  logic clk;
  logic nrst;
  logic [19:0] ev = 20'h0;
  logic [19:0] lv = 20'h0;
  logic [3:0] pins = 4'h0;
  logic signed [15:0] vel = 16'h0;
  logic xs;
  logic pbit;
  logic rbit;
  logic [15:0] msw;
  logic [15:0] dsw;
  logic [15:0] spd;
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] sp;
  int errors = 0;
  int checks = 0;
  int n;
  scsw_status #(.HEARTBEAT_CYC(16), .SAFETY_OPTION(1'b1)) scsw_status_inst (
    .clk(clk), .nrst(nrst), .config_mode(lv[0]), .internal_fault(lv[1]), .config_missing(lv[2]),
    .power_stage_on(lv[3]), .moving(lv[4]), .accelerating(lv[5]), .decelerating(lv[6]), .in_hold(lv[7]),
    .torque_limited(lv[8]), .pos_diff_big(lv[9]), .pos_err_over(lv[10]), .ev_enable_preset(lv[11]),
    .enc_status_err(lv[12]), .over_temp(lv[13]), .over_current(lv[14]), .proc_hot(lv[15]),
    .discrepancy_timeout(lv[16]), .estop_pin(lv[17]), .safety_input_a_n(lv[18]), .safety_input_b_n(lv[19]),
    .ev_invalid_cmd(ev[0]), .ev_move_cmd(ev[1]), .ev_follower_cmd(ev[2]), .ev_jog_cmd(ev[3]),
    .ev_enable_cmd(ev[4]), .ev_disable_cmd(ev[5]), .ev_config_switch(ev[6]), .ev_preset_done(ev[7]),
    .ev_reset_done(ev[8]), .ev_move_end_ok(ev[9]), .ev_follower_end(ev[10]), .ev_home_done(ev[11]),
    .ev_limit_hit(ev[12]), .ev_jog_into_limit(ev[13]), .ev_home_far_limit(ev[14]),
    .ev_stall_stopped_big(ev[15]), .ev_jog_invalid(ev[16]), .ev_jog_valid(ev[17]),
    .ev_link_restored(ev[18]), .enc_power_up_err(ev[19]), .velocity(vel), .host_preset_bit(pbit),
    .host_reset_bit(rbit), .inputs_active_pin(pins), .exchange(xs), .motion_status_word(msw),
    .drive_status_word(dsw), .motor_speed_report(spd)
  );
  scsw_host_model scsw_host_model_inst (
    .clk(clk), .nrst(nrst), .exchange(xs), .host_preset_bit(pbit), .host_reset_bit(rbit),
    .motion_status_word(msw), .drive_status_word(dsw), .motor_speed_report(spd),
    .cap0(w0), .cap1(w1), .cap_sp(sp)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
  endtask
  task automatic xc();
    scsw_host_model_inst.xchg();
  endtask
  task automatic clr_err();
    scsw_host_model_inst.bits(1'b0, 1'b1);
    pulse(8);
    xc();
    chk("ack_rise", 16'h1, w1[13]);
    xc();
    chk("ack_held", 16'h1, w1[13]);
    scsw_host_model_inst.bits(1'b0, 1'b0);
    xc();
    chk("ack_fall", 16'h0, w1[13]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_idle();
    chk("reset_w0", 16'h0, msw);
    chk("reset_w1", 16'h0, dsw);
    xc();
    chk("idle_w0", 16'h4008, w0);
    chk("idle_w1", 16'h0, w1 & 16'hf7f3);
    lv[2:0] = 3'h7;
    xc();
    chk("mode_bits", 16'h5, w0[15:13]);
    lv[2:0] = 3'h0;
  endtask
  task automatic s_cmd();
    int evs[6] = '{0, 1, 5, 6, 4, 4};
    logic [19:0] lvs[6] = '{20'h0, 20'h0, 20'h18, 20'h8, 20'h200, 20'h40000};
    for (int k = 0; k < 6; k++) begin
      lv = lvs[k];
      repeat (4) @(negedge clk);
      pulse(evs[k]);
      xc();
      chk("cmd_err", 16'h1, w0[12]);
      clr_err();
      chk("cmd_err_clr", 16'h0, w0[12]);
    end
    chk("safe_off", 16'h3, {w1[7], w1[5]});
    chk("pos_inv", 16'h1, w0[10]);
    lv = 20'ha08;
    repeat (4) @(negedge clk);
    xc();
    chk("safe_on", 16'h0, {w1[7], w1[5]});
    pulse(4);
    xc();
    chk("preset_enable", 16'h0, w0[12]);
  endtask
  task automatic s_inp();
    for (int k = 0; k < 4; k++) begin
      if (k == 0) begin
        lv[17] = 1'b1;
      end else begin
        pulse(11 + k);
      end
      repeat (5) @(negedge clk);
      xc();
      chk("input_err", 16'h1, w0[11]);
      lv[17] = 1'b0;
      clr_err();
      chk("input_err_clr", 16'h0, w0[11]);
    end
  endtask
  task automatic s_move();
    pulse(9);
    xc();
    chk("done_set", 16'h1, w0[7]);
    pulse(1);
    xc();
    chk("done_move_clr", 16'h0, w0[7]);
    pulse(9);
    scsw_host_model_inst.bits(1'b1, 1'b0);
    pulse(7);
    xc();
    chk("done_preset_clr", 16'h0, w0[7]);
    chk("preset_ack", 16'h1, w1[13]);
    scsw_host_model_inst.bits(1'b0, 1'b0);
    pulse(9);
    clr_err();
    chk("done_reset_clr", 16'h0, w0[7]);
    pulse(11);
    xc();
    chk("home_only", 16'h1, {w0[7], w0[4]});
    lv[7:4] = 4'h3;
    vel = 16'hfed4;
    xc();
    chk("accel_ccw", 16'h32, w0[6:0]);
    chk("speed_neg", 16'hfed4, sp);
    lv[7:4] = 4'hd;
    vel = 16'h0005;
    xc();
    chk("decel_cw_hold", 16'h55, w0[6:0]);
    chk("speed_pos", 16'h0005, sp);
    lv[7:4] = 4'h0;
    vel = 16'h0;
    pulse(2);
    xc();
    chk("follower_run", 16'h0, w0[4:3]);
    pulse(10);
    xc();
    chk("follower_end", 16'h1, w0[3]);
  endtask
  task automatic s_drive();
    lv = 20'hb518;
    pins = 4'hf;
    repeat (4) @(negedge clk);
    xc();
    chk("drive_faults", 16'hd493, w1 & 16'hf7f3);
    lv = 20'h4000;
    pins = 4'h1;
    repeat (4) @(negedge clk);
    xc();
    chk("drive_cur", 16'h4081, w1 & 16'he7f3);
    lv = 20'h0;
    pins = 4'h0;
    clr_err();
    chk("drive_clr", 16'h0, w1 & 16'he7f3);
    pulse(3);
    pulse(16);
    xc();
    chk("jog_inv", 16'h1, w1[9]);
    pulse(17);
    xc();
    chk("jog_ok", 16'h0, w1[9]);
    pulse(18);
    xc();
    chk("link_lost", 16'h1, w1[6]);
    clr_err();
    chk("link_clr", 16'h0, w1[6]);
    lv[16] = 1'b1;
    @(negedge clk);
    lv[16] = 1'b0;
    clr_err();
    chk("discrepancy", 16'h1, w1[8]);
  endtask
  task automatic power_cycle();
    @(negedge clk);
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic s_pinv();
    for (int k = 0; k < 2; k++) begin
      lv = 20'h0;
      power_cycle();
      chk("cycled_w1", 16'h0, dsw);
      xc();
      chk("pinv_idle", 16'h0, {w0[10], w1[8]});
      pulse(k == 0 ? 15 : 19);
      xc();
      chk("pinv_set", 16'h1, w0[10]);
    end
  endtask
  task automatic beat_count(output int c);
    logic b;
    c = 0;
    xc();
    b = w1[11];
    repeat (33) begin
      xc();
      c += int'(w1[11] !== b);
      b = w1[11];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    s_idle();
    s_cmd();
    s_inp();
    s_move();
    s_drive();
    lv = 20'h0;
    beat_count(n);
    chk("beat_run", 16'h1, 16'(n >= 5 && n <= 7));
    lv[0] = 1'b1;
    beat_count(n);
    chk("beat_cfg", 16'h0, 16'(n));
    s_pinv();
    end_of_test();
  end
endmodule
